// *** common/dlsc_pkg.sv ***
// Shared constants and carrier types for the dual supply control logic.
package dlsc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TONE_HZ = 22_000;
  localparam int unsigned SWITCH_MULT = 10;
  localparam int unsigned SWITCH_DIV = CLK_HZ / (TONE_HZ * SWITCH_MULT * 2);
  localparam int unsigned TONE_HALF_DIV = SWITCH_DIV * SWITCH_MULT;
  localparam int unsigned OFF_TIME_MS = 900;
  localparam int unsigned ON_TIME_MS = 20;
  localparam int unsigned TICK_HZ = TONE_HZ * SWITCH_MULT;
  localparam int unsigned OFF_TICKS = (TICK_HZ / 1000) * OFF_TIME_MS;
  localparam int unsigned ON_TICKS = (TICK_HZ / 1000) * ON_TIME_MS;

  // ----------------------------------------
  // Bus address and register fields
  // ----------------------------------------
  localparam logic [5:0] DEV_ADDR_HIGH = 6'h04;
  localparam int unsigned SEL_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Channel A register: sel, static, range, tone, boost, high, on, overload.
  localparam int unsigned A_STATIC = 6;
  localparam int unsigned A_RANGE = 5;
  localparam int unsigned A_TONE = 4;
  localparam int unsigned A_BOOST = 3;
  localparam int unsigned A_HIGH = 2;
  localparam int unsigned A_ON = 1;
  // Channel B register: sel, range, tone, boost, high, on, overtemp, overload.
  localparam int unsigned B_RANGE = 6;
  localparam int unsigned B_TONE = 5;
  localparam int unsigned B_BOOST = 4;
  localparam int unsigned B_HIGH = 3;
  localparam int unsigned B_ON = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {DLSC_NORMAL, DLSC_OFF, DLSC_ON} dlsc_prot_type;
  typedef enum logic [2:0] {DLSC_IDLE, DLSC_RX, DLSC_ACK, DLSC_TX, DLSC_MACK} dlsc_bus_type;

  typedef struct packed {
    logic enable;
    logic high_voltage;
    logic boost;
    logic strong_limit;
    logic tone;
  } dlsc_chan_type;

  typedef struct packed {
    dlsc_prot_type state;
    logic [17:0] count;
    logic flag;
  } dlsc_guard_type;

endpackage

// *** logic/dlsc_top.sv ***
// Control logic of a dual supply regulator with a two-wire slave port.
module dlsc_top (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_sel_in,
  input wire logic supply_good_in,
  input wire logic overtemp_trip_in,
  input wire logic soft_start_done_in,
  input wire logic [1:0] tone_gate_pin_in,
  input wire logic [1:0] force_high_voltage_pin_in,
  input wire logic [1:0] overload_in,
  output logic converter_a_clk_out,
  output logic converter_b_clk_out,
  output dlsc_pkg::dlsc_chan_type chan_a_out,
  output dlsc_pkg::dlsc_chan_type chan_b_out,
  output logic [1:0] overload_flag_out,
  output logic overtemp_flag_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic scl_d;
    logic sda_d;
    dlsc_pkg::dlsc_bus_type bus;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic addressed;
    logic reading;
    logic first;
    logic sda_drive;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [9:0] sw_div;
    logic sw_clk;
    logic tick;
    logic [3:0] tone_div;
    logic tone;
    logic clk_a;
    logic clk_b;
    dlsc_pkg::dlsc_guard_type [1:0] guard;
    dlsc_pkg::dlsc_chan_type chan_a;
    dlsc_pkg::dlsc_chan_type chan_b;
    logic [1:0] ovl_flag;
    logic ot_flag;
  } dlsc_state_type;

  dlsc_state_type r;
  dlsc_state_type next_r;

  // Read-back value of the selected register, with the live status bits.
  function automatic logic [7:0] read_image(input dlsc_state_type s, input logic sel_b);
    logic [7:0] v;
    v = sel_b ? {1'b1, s.ctrl_b[6:2], s.ot_flag, s.ovl_flag[1]} : {1'b0, s.ctrl_a[6:1], s.ovl_flag[0]};
    return v;
  endfunction

  // One overload guard step; returns the new guard state, count and overload flag.
  function automatic dlsc_pkg::dlsc_guard_type guard_step(input dlsc_pkg::dlsc_guard_type g,
      input logic tick, input logic static_mode, input logic ovl, input logic enabled,
      input logic soft_done);
    dlsc_pkg::dlsc_guard_type n;
    n = g;
    if (!enabled) begin
      n.state = dlsc_pkg::DLSC_NORMAL;
      n.count = '0;
      n.flag = 1'b0;
    end else if (static_mode) begin
      n.state = dlsc_pkg::DLSC_NORMAL;
      n.count = '0;
      n.flag = ovl;
    end else begin
      unique case (g.state)
        dlsc_pkg::DLSC_NORMAL: begin
          if (ovl) begin
            n.state = dlsc_pkg::DLSC_OFF;
            n.count = '0;
            n.flag = 1'b1;
          end else if (soft_done) begin
            n.flag = 1'b0;
          end
        end
        dlsc_pkg::DLSC_OFF: begin
          if (tick) begin
            if (g.count == 18'(dlsc_pkg::OFF_TICKS - 1)) begin
              n.state = dlsc_pkg::DLSC_ON;
              n.count = '0;
            end else begin
              n.count = g.count + 18'h1;
            end
          end
        end
        dlsc_pkg::DLSC_ON: begin
          if (tick) begin
            if (g.count == 18'(dlsc_pkg::ON_TICKS - 1)) begin
              n.count = '0;
              if (ovl) begin
                n.state = dlsc_pkg::DLSC_OFF;
              end else begin
                n.state = dlsc_pkg::DLSC_NORMAL;
                n.flag = 1'b0;
              end
            end else begin
              n.count = g.count + 18'h1;
            end
          end
        end
        default: begin
          n.state = dlsc_pkg::DLSC_NORMAL;
        end
      endcase
    end
    return n;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] rx;
    logic ovl_a;
    logic ovl_b;
    logic run_a;
    logic run_b;
    logic tone_a;
    logic tone_b;
    next_r = r;
    scl = r.sync2[0];
    sda = r.sync2[1];
    scl_rise = scl && !r.scl_d;
    scl_fall = !scl && r.scl_d;
    start_c = scl && r.scl_d && r.sda_d && !sda;
    stop_c = scl && r.scl_d && !r.sda_d && sda;
    rx = {r.shift[6:0], sda};
    ovl_a = r.sync2[8];
    ovl_b = r.sync2[9];
    // Independent enables, gated by overtemp and off interval.
    run_a = r.ctrl_a[dlsc_pkg::A_ON] && !r.ot_flag && r.guard[0].state != dlsc_pkg::DLSC_OFF;
    run_b = r.ctrl_b[dlsc_pkg::B_ON] && !r.ot_flag && r.guard[1].state != dlsc_pkg::DLSC_OFF;
    tone_a = r.tone && (r.ctrl_a[dlsc_pkg::A_TONE] || r.sync2[4]);
    tone_b = r.tone && (r.ctrl_b[dlsc_pkg::B_TONE] || r.sync2[5]);
    next_r.sync1 = {2'b00, supply_good_in, overtemp_trip_in, soft_start_done_in, addr_sel_in,
                    overload_in, force_high_voltage_pin_in, tone_gate_pin_in, 2'b00, sda_in, scl_in};
    next_r.sync2 = r.sync1;
    next_r.scl_d = scl;
    next_r.sda_d = sda;

    // Switching clock at ten times tone.
    next_r.tick = 1'b0;
    if (r.sw_div == 10'(dlsc_pkg::SWITCH_DIV - 1)) begin
      next_r.sw_div = '0;
      next_r.sw_clk = !r.sw_clk;
      next_r.tick = !r.sw_clk;
      if (r.tone_div == 4'(dlsc_pkg::SWITCH_MULT - 1)) begin
        next_r.tone_div = '0;
        next_r.tone = !r.tone;
      end else begin
        next_r.tone_div = r.tone_div + 4'h1;
      end
    end else begin
      next_r.sw_div = r.sw_div + 10'h1;
    end

    // Two-wire slave; start or stop anywhere resets the byte engine.
    if (start_c) begin
      next_r.bus = dlsc_pkg::DLSC_RX;
      next_r.bit_cnt = '0;
      next_r.first = 1'b1;
      next_r.addressed = 1'b0;
      next_r.sda_drive = 1'b0;
    end else if (stop_c) begin
      next_r.bus = dlsc_pkg::DLSC_IDLE;
      next_r.sda_drive = 1'b0;
    end else begin
      unique case (r.bus)
        dlsc_pkg::DLSC_IDLE: begin
          next_r.sda_drive = 1'b0;
        end
        dlsc_pkg::DLSC_RX: begin
          if (scl_rise) begin
            next_r.shift = rx;
            next_r.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall && r.bit_cnt == 4'h8) begin
            next_r.bit_cnt = '0;
            next_r.bus = dlsc_pkg::DLSC_ACK;
            if (r.first) begin
              next_r.addressed = (r.shift[7:2] == dlsc_pkg::DEV_ADDR_HIGH)
                                 && (r.shift[1] == r.sync2[10]);
              next_r.reading = r.shift[0];
              next_r.sda_drive = (r.shift[7:2] == dlsc_pkg::DEV_ADDR_HIGH)
                                 && (r.shift[1] == r.sync2[10]) && r.sync2[13];
            end else begin
              next_r.sda_drive = r.addressed && r.sync2[13];
              if (r.addressed && r.sync2[13]) begin
                if (r.shift[dlsc_pkg::SEL_BIT]) begin
                  next_r.ctrl_b = {1'b0, r.shift[6:2], 2'b00};
                end else begin
                  next_r.ctrl_a = {1'b0, r.shift[6:1], 1'b0};
                end
              end
            end
          end
        end
        dlsc_pkg::DLSC_ACK: begin
          if (scl_fall) begin
            next_r.first = 1'b0;
            if (r.addressed && r.reading && r.sda_drive) begin
              next_r.bus = dlsc_pkg::DLSC_TX;
              next_r.shift = read_image(r, 1'b0);
              next_r.sda_drive = !next_r.shift[7];
            end else if (r.addressed && r.sync2[13]) begin
              next_r.bus = dlsc_pkg::DLSC_RX;
              next_r.sda_drive = 1'b0;
            end else begin
              next_r.bus = dlsc_pkg::DLSC_IDLE;
              next_r.sda_drive = 1'b0;
            end
          end
        end
        dlsc_pkg::DLSC_TX: begin
          // Bits leave MSB first; the second read returns the other register.
          if (scl_fall) begin
            if (r.bit_cnt == 4'h7) begin
              next_r.bit_cnt = '0;
              next_r.bus = dlsc_pkg::DLSC_MACK;
              next_r.sda_drive = 1'b0;
              next_r.shift = read_image(r, !r.shift[dlsc_pkg::SEL_BIT]);
            end else begin
              next_r.bit_cnt = r.bit_cnt + 4'h1;
              next_r.sda_drive = !r.shift[3'(6 - r.bit_cnt)];
            end
          end
        end
        dlsc_pkg::DLSC_MACK: begin
          if (scl_rise) begin
            next_r.reading = !sda;
          end else if (scl_fall) begin
            if (r.reading) begin
              next_r.bus = dlsc_pkg::DLSC_TX;
              next_r.shift = read_image(r, r.shift[dlsc_pkg::SEL_BIT]);
              next_r.sda_drive = !next_r.shift[7];
            end else begin
              next_r.bus = dlsc_pkg::DLSC_IDLE;
            end
          end
        end
        default: begin
          next_r.bus = dlsc_pkg::DLSC_IDLE;
        end
      endcase
    end

    if (r.sync2[12] || !r.sync2[13]) begin
      next_r.ctrl_a = dlsc_pkg::CTRL_RESET;
      next_r.ctrl_b = dlsc_pkg::CTRL_RESET;
    end
    if (!r.sync2[13]) begin
      next_r.bus = dlsc_pkg::DLSC_IDLE;
      next_r.sda_drive = 1'b0;
    end
    next_r.ot_flag = r.sync2[12];

    next_r.guard[0] = guard_step(r.guard[0], r.tick, r.ctrl_a[dlsc_pkg::A_STATIC], ovl_a,
                                 r.ctrl_a[dlsc_pkg::A_ON], r.sync2[11]);
    next_r.guard[1] = guard_step(r.guard[1], r.tick, r.ctrl_a[dlsc_pkg::A_STATIC], ovl_b,
                                 r.ctrl_b[dlsc_pkg::B_ON], r.sync2[11]);
    next_r.ovl_flag = {next_r.guard[1].flag, next_r.guard[0].flag};

    next_r.chan_a.enable = run_a;
    next_r.chan_b.enable = run_b;
    // Converter clocks are registered so that no gating glitch reaches the pins.
    next_r.clk_a = next_r.sw_clk && run_a;
    next_r.clk_b = next_r.sw_clk && run_b;
    next_r.chan_a.high_voltage = run_a && (r.ctrl_a[dlsc_pkg::A_HIGH] || r.sync2[6]);
    next_r.chan_b.high_voltage = run_b && (r.ctrl_b[dlsc_pkg::B_HIGH] || r.sync2[7]);
    next_r.chan_a.boost = run_a && r.ctrl_a[dlsc_pkg::A_BOOST];
    next_r.chan_b.boost = run_b && r.ctrl_b[dlsc_pkg::B_BOOST];
    next_r.chan_a.strong_limit = r.ctrl_a[dlsc_pkg::A_RANGE];
    next_r.chan_b.strong_limit = r.ctrl_b[dlsc_pkg::B_RANGE];
    next_r.chan_a.tone = run_a && tone_a;
    next_r.chan_b.tone = run_b && tone_b;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = r.sda_drive;
  assign converter_a_clk_out = r.clk_a;
  assign converter_b_clk_out = r.clk_b;
  assign chan_a_out = r.chan_a;
  assign chan_b_out = r.chan_b;
  assign overload_flag_out = r.ovl_flag;
  assign overtemp_flag_out = r.ot_flag;

endmodule

// *** tb/dlsc_top_chk.sv ***
// Concurrent checks on the supply control logic ports.
module dlsc_top_chk (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic supply_good_in,
  input wire logic overtemp_trip_in,
  input wire logic [1:0] tone_gate_pin_in,
  input wire logic [1:0] force_high_voltage_pin_in,
  input wire logic [1:0] overload_in,
  input wire logic converter_a_clk_out,
  input wire dlsc_pkg::dlsc_chan_type chan_a_out,
  input wire dlsc_pkg::dlsc_chan_type chan_b_out,
  input wire logic [1:0] overload_flag_out,
  input wire logic overtemp_flag_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // ----
  // Causes are held five cycles since the synchronisers add three or four.
  // ----
  // ----
  // Tone watch: while channel A is keyed its tone must keep toggling.
  // ----
  logic tone_last;
  logic [12:0] tone_quiet;
  always_ff @(posedge mclk_in) begin
    tone_last <= chan_a_out.tone;
    if (!nrst_in || !tone_gate_pin_in[0] || !chan_a_out.enable || chan_a_out.tone != tone_last) begin
      tone_quiet <= '0;
    end else if (tone_quiet != 13'h1fff) begin
      tone_quiet <= tone_quiet + 13'h1;
    end
  end
  sequence s_unpowered;
    !supply_good_in [*5];
  endsequence
  sequence s_hot;
    overtemp_flag_out [*2];
  endsequence
  chk_tone_gate: assert property (tone_quiet <= 13'(dlsc_pkg::TONE_HALF_DIV + 8))
    else $error("tone absent while gate held high");
  chk_no_ack: assert property (s_unpowered |-> !sda_oe_out)
    else $error("data line pulled without supply");
  chk_regs_down: assert property (s_unpowered |-> !chan_a_out.enable && !chan_b_out.enable)
    else $error("channel enabled without supply");
  chk_ack_stands: assert property (sda_oe_out && scl_in |=> sda_oe_out)
    else $error("data line released while clock high");
  chk_sda_low: assert property (sda_oe_out |-> sda_out == 1'b0)
    else $error("data line driven high");
  chk_ot_set: assert property ($rose(overtemp_trip_in) |-> ##[1:5] overtemp_flag_out)
    else $error("overtemp flag late");
  chk_ot_clear: assert property ($fell(overtemp_trip_in) |-> ##[1:5] !overtemp_flag_out)
    else $error("overtemp flag stuck");
  chk_ot_off: assert property (s_hot |-> !chan_a_out.enable && !chan_b_out.enable)
    else $error("channel on while overheated");
  chk_ovl_flag: assert property ((chan_a_out.enable && overload_in[0]) [*5] |-> overload_flag_out[0])
    else $error("overload flag not raised");
  chk_clk_gated: assert property (!chan_a_out.enable [*3] |-> !converter_a_clk_out)
    else $error("switching clock runs while disabled");
  chk_force_b: assert property ((force_high_voltage_pin_in[1] && chan_b_out.enable) [*5]
    |-> chan_b_out.high_voltage)
    else $error("force pin ignored");
endmodule
bind dlsc_top dlsc_top_chk i_chk (.mclk_in, .nrst_in, .scl_in, .sda_out, .sda_oe_out, .supply_good_in,
  .overtemp_trip_in, .tone_gate_pin_in, .force_high_voltage_pin_in, .overload_in, .converter_a_clk_out,
  .chan_a_out, .chan_b_out, .overload_flag_out, .overtemp_flag_out);

// *** tb/dlsc_host.sv ***
// Two-wire bus master model standing in for the host processor.
module dlsc_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock and data idle high; a high data drive means released.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wait_q(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic start();
    sda_out <= 1'b0;
    wait_q(4);
    scl_out <= 1'b0;
    wait_q(2);
  endtask
  task automatic stop();
    sda_out <= 1'b0;
    wait_q(2);
    scl_out <= 1'b1;
    wait_q(2);
    sda_out <= 1'b1;
    wait_q(4);
  endtask
  // Data moves only while clock low.
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    wait_q(2);
    scl_out <= 1'b1;
    wait_q(4);
    r = sda_in;
    scl_out <= 1'b0;
    wait_q(2);
  endtask
  // Eight bits first bit highest, then acknowledge.
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the dual supply control logic.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, scl, host_sda, sda_o, sda_oe, sg, ot, cka, ckb, overtemp_flag;
  logic [1:0] gate, fhv, ovl, olf;
  logic [7:0] d0, d1;
  dlsc_pkg::dlsc_chan_type cha, chb;
  wire logic sda;
  int errors, num_checks, n;
  assign sda = host_sda & (sda_oe ? sda_o : 1'b1);
  dlsc_host i_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(host_sda));
  dlsc_top i_dut (.mclk_in(clk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .addr_sel_in(1'b0), .supply_good_in(sg), .overtemp_trip_in(ot),
    .soft_start_done_in(1'b1), .tone_gate_pin_in(gate), .force_high_voltage_pin_in(fhv),
    .overload_in(ovl), .converter_a_clk_out(cka), .converter_b_clk_out(ckb), .chan_a_out(cha),
    .chan_b_out(chb), .overload_flag_out(olf), .overtemp_flag_out(overtemp_flag));
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] d, input logic exp);
    logic a;
    i_host.start();
    i_host.put_byte(8'h10, a);
    check("address ack", a, exp);
    i_host.put_byte(d, a);
    check("data ack", a, exp);
    i_host.stop();
    settle();
  endtask
  task automatic rd();
    logic a;
    i_host.start();
    i_host.put_byte(8'h11, a);
    check("read ack", a, 1'b1);
    i_host.get_byte(1'b0, d0);
    i_host.get_byte(1'b1, d1);
    i_host.stop();
  endtask
  // Waits for a rising switching clock edge, bounded so a dead clock cannot hang.
  task automatic gap(input logic sel, output int k);
    logic last, now;
    k = 0;
    last = 1'b1;
    now = sel ? ckb : cka;
    while (!(now === 1'b1 && last === 1'b0) && k < 3000) begin
      @(posedge clk);
      last = now;
      now = sel ? ckb : cka;
      k++;
    end
  endtask
  // Waits until one channel's tone output shows the given level, bounded.
  task automatic tone_at(input logic sel, input logic lvl, output int k);
    k = 0;
    while ((sel ? chb.tone : cha.tone) !== lvl && k < 6000) begin
      @(posedge clk);
      k++;
    end
  endtask
  // ----
  // Clock, watchdog and tests
  // ----
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #400us;
    errors++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    sg = 1'b1;
    ot = 1'b0;
    gate = 2'h0;
    fhv = 2'h0;
    ovl = 2'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    settle();
    check("chan a reset", cha, 5'h00);
    check("chan b reset", chb, 5'h00);
    check("flags reset", {olf, overtemp_flag}, 3'h0);
    $display("test reset done");
    sg <= 1'b0;
    wr(8'h6e, 1'b0);
    sg <= 1'b1;
    settle();
    check("chan a unpowered", cha, 5'h00);
    $display("test supply done");
    // Start in static limiting; tone force low while keying.
    wr(8'h6e, 1'b1);
    check("chan a", cha, 5'h1e);
    check("chan b off", chb, 5'h00);
    gate <= 2'h1;
    settle();
    tone_at(1'b0, 1'b1, n);
    check("chan a keyed", cha, 5'h1f);
    tone_at(1'b0, 1'b0, n);
    tone_at(1'b0, 1'b1, n);
    check("tone half period", n, dlsc_pkg::CLK_HZ / (2 * dlsc_pkg::TONE_HZ));
    gate <= 2'h0;
    settle();
    check("chan a unkeyed", cha, 5'h1e);
    // Voltage bit low while the force pin is used.
    wr(8'ha4, 1'b1);
    tone_at(1'b1, 1'b1, n);
    check("chan b tone", chb, 5'h11);
    fhv <= 2'h2;
    settle();
    tone_at(1'b1, 1'b1, n);
    check("chan b forced", chb, 5'h19);
    fhv <= 2'h0;
    rd();
    check("read a", d0, 8'h6e);
    check("read b", d1, 8'ha4);
    $display("test control done");
    gap(1'b0, n);
    gap(1'b0, n);
    check("period a", n, 2 * dlsc_pkg::SWITCH_DIV);
    gap(1'b1, n);
    gap(1'b1, n);
    check("period b", n, 2 * dlsc_pkg::SWITCH_DIV);
    $display("test switching done");
    ovl <= 2'h1;
    settle();
    check("static flag set", olf, 2'h1);
    check("static still on", cha.enable, 1'b1);
    ovl <= 2'h0;
    settle();
    check("static flag clear", olf, 2'h0);
    // The off interval lasts far beyond the run, so only its onset is seen.
    wr(8'h2e, 1'b1);
    ovl <= 2'h1;
    settle();
    check("dynamic flag", olf, 2'h1);
    check("output cut", cha.enable, 1'b0);
    ovl <= 2'h0;
    $display("test overload done");
    ot <= 1'b1;
    settle();
    check("overtemp set", overtemp_flag, 1'b1);
    check("stages off", {cha.enable, chb.enable}, 2'h0);
    ot <= 1'b0;
    settle();
    check("overtemp clear", overtemp_flag, 1'b0);
    check("b cleared", chb, 5'h00);
    wr(8'ha4, 1'b1);
    tone_at(1'b1, 1'b1, n);
    check("b restored", chb, 5'h11);
    $display("test overtemp done");
    test_done();
  end
endmodule
